// ===== hw/ars_pkg.sv
// ars_pkg: constants and state type for the result and status logic.
// assumes a 32-bit axi4-lite register bus with 8-bit byte addresses.
package ars_pkg;

  // number of sample slots and result registers
  localparam int unsigned NSLOT = 8;

  // register byte offsets
  localparam logic [7:0] OFS_CONV_STATUS = 8'h00;
  localparam logic [7:0] OFS_LIMIT_STATUS = 8'h04;
  localparam logic [7:0] OFS_ZC_STATUS = 8'h08;
  localparam logic [7:0] OFS_CONTROL = 8'h0C;
  localparam logic [7:0] OFS_RESULT_BASE = 8'h20;

  // limit values that mean checking is off
  localparam logic [15:0] HIGH_LIMIT_OFF = 16'h7FF8;
  localparam logic [15:0] LOW_LIMIT_OFF = 16'h0000;

  // converter_status field positions
  localparam int unsigned ST_HL_FLAG = 8;
  localparam int unsigned ST_LL_FLAG = 9;
  localparam int unsigned ST_ZC_FLAG = 10;

  // control register field positions and reset
  localparam int unsigned CTRL_HL_IE = 0;
  localparam int unsigned CTRL_LL_IE = 1;
  localparam int unsigned CTRL_ZC_IE = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // result layout
  localparam int unsigned RES_SIGN = 15;
  localparam int unsigned RES_MSB = 14;
  localparam int unsigned RES_LSB = 3;

  // zero-crossing selections per slot
  localparam logic [1:0] ZC_OFF = 2'h0;
  localparam logic [1:0] ZC_POS_NEG = 2'h1;
  localparam logic [1:0] ZC_NEG_POS = 2'h2;
  localparam logic [1:0] ZC_ANY = 2'h3;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // whole state of the block
  typedef struct packed {
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [15:0] rdata;
    logic [1:0] rresp;
    logic [7:0] ready;
    logic [15:0] lstat;
    logic [7:0] zstat;
    logic hl_flag;
    logic ll_flag;
    logic zc_flag;
    logic [2:0] ctrl;
    logic [7:0] prev_sign;
    logic [127:0] result;
    logic hl_irq;
    logic ll_irq;
    logic zc_irq;
  } ars_state_t;

endpackage : ars_pkg

// ===== hw/ars_top.sv
// ars_top: result registers, ready flags, limit and zero-crossing status.
// assumes converter results arrive on i_clk, one cycle wide per sample,
// and limit, offset and zero-crossing settings come from neighbour logic.
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps

module ars_top (
  input wire logic i_clk,
  input wire logic i_rst_n,
  // axi4-lite write address and data
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // axi4-lite read
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // converter a and b results
  input wire logic i_conv_a_valid,
  input wire logic [2:0] i_conv_a_slot,
  input wire logic [11:0] i_conv_a_raw,
  input wire logic i_conv_b_valid,
  input wire logic [2:0] i_conv_b_slot,
  input wire logic [11:0] i_conv_b_raw,
  // per-slot settings, slot n in bits 16n+15..16n, zero-cross select in bits 2n+1..2n
  input wire logic [127:0] i_high_limit,
  input wire logic [127:0] i_low_limit,
  input wire logic [127:0] i_offset,
  input wire logic [15:0] i_zero_cross_select,
  // interrupt requests
  output logic o_high_limit_irq,
  output logic o_low_limit_irq,
  output logic o_zero_cross_irq
);

  ars_pkg::ars_state_t st_r;
  ars_pkg::ars_state_t st_nxt;

  // per-slot events from the converters
  logic [7:0] hit_v;
  logic [7:0] hl_ev_v;
  logic [7:0] ll_ev_v;
  logic [7:0] zc_ev_v;
  logic [7:0] sign_v;
  logic [127:0] conv_res_v;

  genvar n;

  // one comparison and subtraction path per slot
  generate
    for (n = 0; n < ars_pkg::NSLOT; n++) begin : g_slot
      logic hit_a;
      logic hit_b;
      logic [11:0] raw;
      logic [15:0] raw16;
      logic [15:0] hl16;
      logic [15:0] ll16;
      logic [15:0] ofs16;
      logic [15:0] diff;
      logic [1:0] sel;
      logic changed;
      logic zc_hit;

      // a and b name the same slot: converter a wins
      assign hit_a = i_conv_a_valid && (i_conv_a_slot == 3'(n));
      assign hit_b = i_conv_b_valid && (i_conv_b_slot == 3'(n));
      assign hit_v[n] = hit_a | hit_b;
      assign raw = hit_a ? i_conv_a_raw : i_conv_b_raw;

      // raw and settings aligned into the 14..3 field
      assign raw16 = {1'b0, raw, 3'h0};
      assign hl16 = {1'b0, i_high_limit[16*n+ars_pkg::RES_LSB +: 12], 3'h0};
      assign ll16 = {1'b0, i_low_limit[16*n+ars_pkg::RES_LSB +: 12], 3'h0};
      assign ofs16 = {1'b0, i_offset[16*n+ars_pkg::RES_LSB +: 12], 3'h0};

      // sign falls out of the 16-bit subtraction
      assign diff = raw16 - ofs16;
      assign conv_res_v[16*n +: 16] = diff;
      assign sign_v[n] = diff[ars_pkg::RES_SIGN];

      // limits look at raw value, not the corrected one
      assign hl_ev_v[n] = hit_v[n]
        && (i_high_limit[16*n +: 16] != ars_pkg::HIGH_LIMIT_OFF)
        && (raw16 > hl16);
      // a zero low limit is the off setting, as after reset
      assign ll_ev_v[n] = hit_v[n]
        && (i_low_limit[16*n +: 16] != ars_pkg::LOW_LIMIT_OFF)
        && (raw16 < ll16);

      // sign comparison against previous sample of the slot
      assign sel = i_zero_cross_select[2*n +: 2];
      assign changed = sign_v[n] ^ st_r.prev_sign[n];

      always_comb begin
        case (sel)
          ars_pkg::ZC_ANY: zc_hit = changed;
          ars_pkg::ZC_POS_NEG: zc_hit = changed & sign_v[n];
          ars_pkg::ZC_NEG_POS: zc_hit = changed & ~sign_v[n];
          ars_pkg::ZC_OFF: zc_hit = 1'b0;
          default: zc_hit = 1'b0;
        endcase
      end

      assign zc_ev_v[n] = hit_v[n] & zc_hit;
    end
  endgenerate

  // write path helpers
  logic aw_hs;
  logic w_hs;
  logic do_wr;
  logic wr_ok;
  logic [15:0] wmask;
  logic [15:0] wval;
  logic [2:0] widx;
  logic [15:0] wofs;
  logic [15:0] wres;
  logic [15:0] wones;
  logic wr_res;
  logic wr_lstat;
  logic wr_zstat;
  logic wr_ctrl;

  // read path helpers
  logic ar_hs;
  logic [2:0] ridx;
  logic rd_ok;
  logic [15:0] rval;
  logic [7:0] rd_clr;

  // handshakes
  assign aw_hs = i_awvalid & st_r.awready;
  assign w_hs = i_wvalid & st_r.wready;
  assign ar_hs = i_arvalid & st_r.arready;

  // write executes once address and data are both held
  assign do_wr = st_r.aw_got & st_r.w_got & ~st_r.bvalid;
  assign widx = st_r.awaddr[4:2];
  assign wmask = {{8{st_r.wstrb[1]}}, {8{st_r.wstrb[0]}}};
  assign wval = st_r.wdata & wmask;
  assign wones = do_wr ? wval : 16'h0000;

  // write decode
  // misaligned result address refused, same as on the read side
  assign wr_res = do_wr && (st_r.awaddr[7:5] == ars_pkg::OFS_RESULT_BASE[7:5])
    && (st_r.awaddr[1:0] == 2'h0);
  assign wr_lstat = do_wr && (st_r.awaddr == ars_pkg::OFS_LIMIT_STATUS);
  assign wr_zstat = do_wr && (st_r.awaddr == ars_pkg::OFS_ZC_STATUS);
  assign wr_ctrl = do_wr && (st_r.awaddr == ars_pkg::OFS_CONTROL);
  // status register takes writes silently
  assign wr_ok = wr_res | wr_lstat | wr_zstat | wr_ctrl
    | (st_r.awaddr == ars_pkg::OFS_CONV_STATUS);

  // software result: only the field is kept, offset removed
  assign wofs = {1'b0, i_offset[16*widx+ars_pkg::RES_LSB +: 12], 3'h0};
  assign wres = {1'b0, wval[ars_pkg::RES_MSB:ars_pkg::RES_LSB], 3'h0} - wofs;

  // read decode
  assign ridx = i_araddr[4:2];
  always_comb begin
    rd_ok = 1'b1;
    rd_clr = 8'h00;
    rval = 16'h0000;
    if (i_araddr[7:5] == ars_pkg::OFS_RESULT_BASE[7:5] && i_araddr[1:0] == 2'h0) begin
      rval = st_r.result[16*ridx +: 16];
      // every read counts, a debugger read too
      rd_clr[ridx] = ar_hs;
    end else begin
      case (i_araddr)
        ars_pkg::OFS_CONV_STATUS: begin
          rval[7:0] = st_r.ready;
          rval[ars_pkg::ST_HL_FLAG] = st_r.hl_flag;
          rval[ars_pkg::ST_LL_FLAG] = st_r.ll_flag;
          rval[ars_pkg::ST_ZC_FLAG] = st_r.zc_flag;
        end
        ars_pkg::OFS_LIMIT_STATUS: rval = st_r.lstat;
        ars_pkg::OFS_ZC_STATUS: rval = {8'h00, st_r.zstat};
        ars_pkg::OFS_CONTROL: rval = {13'h0, st_r.ctrl};
        default: rd_ok = 1'b0;
      endcase
    end
  end

  // next state
  always_comb begin
    st_nxt = st_r;

    // capture write address and data in either order
    if (aw_hs) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = i_awaddr;
    end
    if (w_hs) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = i_wdata[15:0];
      st_nxt.wstrb = i_wstrb[1:0];
    end
    if (do_wr) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = wr_ok ? ars_pkg::RESP_OKAY : ars_pkg::RESP_SLVERR;
    end else if (st_r.bvalid && i_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    // ready only when the slot for that channel is free
    st_nxt.awready = ~st_nxt.aw_got & ~st_nxt.bvalid;
    st_nxt.wready = ~st_nxt.w_got & ~st_nxt.bvalid;

    // read answers one edge after the address is taken
    if (ar_hs) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rval;
      st_nxt.rresp = rd_ok ? ars_pkg::RESP_OKAY : ars_pkg::RESP_SLVERR;
    end else if (st_r.rvalid && i_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    st_nxt.arready = ~st_nxt.rvalid;

    // control register
    if (wr_ctrl) begin
      st_nxt.ctrl = wval[2:0];
    end

    // software result write; a conversion in the same cycle wins
    if (wr_res) begin
      st_nxt.result[16*widx +: 16] = wres;
    end
    for (int i = 0; i < ars_pkg::NSLOT; i++) begin
      if (hit_v[i]) begin
        st_nxt.result[16*i +: 16] = conv_res_v[16*i +: 16];
        st_nxt.prev_sign[i] = sign_v[i];
      end
    end

    // ready: a conversion landing with a read keeps the flag
    st_nxt.ready = (st_r.ready & ~rd_clr) | hit_v;

    // sticky status, set beats a same-cycle clear
    st_nxt.lstat = (st_r.lstat & ~(wr_lstat ? wones : 16'h0000))
      | {hl_ev_v, ll_ev_v};
    st_nxt.zstat = (st_r.zstat & ~(wr_zstat ? wones[7:0] : 8'h00)) | zc_ev_v;

    // summary flags drop once no status bit of theirs is left
    st_nxt.hl_flag = (|hl_ev_v) | (st_r.hl_flag & (|st_nxt.lstat[15:8]));
    st_nxt.ll_flag = (|ll_ev_v) | (st_r.ll_flag & (|st_nxt.lstat[7:0]));
    st_nxt.zc_flag = (|zc_ev_v) | (st_r.zc_flag & (|st_nxt.zstat));

    // interrupt requests gated by enables
    st_nxt.hl_irq = st_nxt.hl_flag & st_nxt.ctrl[ars_pkg::CTRL_HL_IE];
    st_nxt.ll_irq = st_nxt.ll_flag & st_nxt.ctrl[ars_pkg::CTRL_LL_IE];
    st_nxt.zc_irq = st_nxt.zc_flag & st_nxt.ctrl[ars_pkg::CTRL_ZC_IE];
  end

  // state register; bus readies rise at the first edge after reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
      st_r.ctrl <= ars_pkg::CTRL_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign o_awready = st_r.awready;
  assign o_wready = st_r.wready;
  assign o_bvalid = st_r.bvalid;
  assign o_bresp = st_r.bresp;
  assign o_arready = st_r.arready;
  assign o_rvalid = st_r.rvalid;
  assign o_rdata = {16'h0000, st_r.rdata};
  assign o_rresp = st_r.rresp;
  assign o_high_limit_irq = st_r.hl_irq;
  assign o_low_limit_irq = st_r.ll_irq;
  assign o_zero_cross_irq = st_r.zc_irq;

endmodule : ars_top

// ===== tb/ars_top_asserts.sv
// ars_top_asserts: bus reply timing and result layout checks.
// sees only ars_top ports; bound from the bench top file.
`timescale 1ns/1ps
module ars_top_asserts (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic i_bready
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic res_rd_r;
  // remembers whether the read in flight targets a result register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      res_rd_r <= 1'h0;
    end else if (i_arvalid && o_arready) begin
      res_rd_r <= (i_araddr[7:5] == 3'h1) && (i_araddr[1:0] == 2'h0);
    end
  end
  // transfer starts
  sequence s_ar; i_arvalid && o_arready; endsequence
  sequence s_bad; i_arvalid && o_arready && i_araddr == 8'h10; endsequence
  sequence s_wr; i_awvalid && o_awready && i_wvalid && o_wready; endsequence
  a_read_answer: assert property (s_ar |=> o_rvalid)
    else $error("read reply late");
  a_read_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read reply dropped early");
  a_ar_blocked: assert property (o_rvalid |-> !o_arready)
    else $error("read address accepted while busy");
  a_write_answer: assert property (s_wr |-> ##2 o_bvalid)
    else $error("write reply late");
  a_write_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write reply dropped early");
  a_aw_blocked: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write accepted while busy");
  a_result_shape: assert property (
    o_rvalid && res_rd_r |-> o_rdata[31:16] == 16'h0 && o_rdata[2:0] == 3'h0)
    else $error("result low bits not zero");
  a_unmapped_read: assert property (s_bad |=> o_rresp == 2'h2 && o_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule : ars_top_asserts

// ===== tb/ars_top_bench.sv
// ars_top_bench: directed tests of results, ready flags and status.
// drives every ars_top port itself; 100 MHz clock, no partner model.
`timescale 1ns/1ps
module ars_top_bench;
  localparam logic [7:0] ST = ars_pkg::OFS_CONV_STATUS;
  localparam logic [7:0] LS = ars_pkg::OFS_LIMIT_STATUS;
  localparam logic [7:0] ZS = ars_pkg::OFS_ZC_STATUS;
  localparam logic [7:0] CT = ars_pkg::OFS_CONTROL;
  localparam logic [7:0] RB = ars_pkg::OFS_RESULT_BASE;
  logic i_clk = 1'h0;
  logic i_rst_n = 1'h0;
  logic [7:0] i_awaddr = 8'h0, i_araddr = 8'h0;
  logic [31:0] i_wdata = 32'h0;
  logic [3:0] i_wstrb = 4'hF;
  logic i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0, i_arvalid = 1'h0, i_rready = 1'h0;
  logic i_conv_a_valid = 1'h0, i_conv_b_valid = 1'h0;
  logic [2:0] i_conv_a_slot = 3'h0, i_conv_b_slot = 3'h0;
  logic [11:0] i_conv_a_raw = 12'h0, i_conv_b_raw = 12'h0;
  logic [127:0] i_high_limit = {8{16'h7FF8}}, i_low_limit = '0, i_offset = '0;
  logic [15:0] i_zero_cross_select = 16'h0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic o_high_limit_irq, o_low_limit_irq, o_zero_cross_irq;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata;
  int failures = 0;
  int tests_run = 0;
  ars_top uut (.*);
  // free running clock
  always #5 i_clk = ~i_clk;
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_data
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    chk_data({30'h0, got}, {30'h0, exp});
  endtask : chk_resp
  // bounded wait, sampled mid-cycle so edge updates have landed
  // which: 0 aw and w ready, 1 write reply, 2 ar ready, 3 read reply
  task automatic wait_hi(input int which);
    int n = 0;
    logic s = 1'h0;
    do begin
      @(negedge i_clk);
      n++;
      case (which)
        0: s = o_awready & o_wready;
        1: s = o_bvalid;
        2: s = o_arready;
        default: s = o_rvalid;
      endcase
    end while (s !== 1'h1 && n < 50);
    if (s !== 1'h1) begin
      failures++;
      final_report();
    end
  endtask : wait_hi
  // aw and w offered together; readies rise together when idle
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= {16'h0, d};
    i_awvalid <= 1'h1;
    i_wvalid <= 1'h1;
    wait_hi(0);
    @(posedge i_clk);
    i_awvalid <= 1'h0;
    i_wvalid <= 1'h0;
    wait_hi(1);
    chk_resp(o_bresp, er);
    @(posedge i_clk);
    i_bready <= 1'h1;
    @(posedge i_clk);
    i_bready <= 1'h0;
  endtask : wr
  // rready raised late on purpose so the reply must stand
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1'h1;
    wait_hi(2);
    @(posedge i_clk);
    i_arvalid <= 1'h0;
    wait_hi(3);
    chk_data(o_rdata, e);
    chk_resp(o_rresp, er);
    @(posedge i_clk);
    i_rready <= 1'h1;
    @(posedge i_clk);
    i_rready <= 1'h0;
  endtask : rd_chk
  // one sample per call, landed before any status read
  task automatic conv(input logic [2:0] s, input logic [11:0] v);
    @(posedge i_clk);
    i_conv_a_valid <= 1'h1;
    i_conv_a_slot <= s;
    i_conv_a_raw <= v;
    @(posedge i_clk);
    i_conv_a_valid <= 1'h0;
  endtask : conv
  // raw code minus offset field, both left aligned at bit 3
  function automatic logic [31:0] res(input logic [11:0] v, input logic [15:0] o);
    return {16'h0, {1'h0, v, 3'h0} - {1'h0, o[14:3], 3'h0}};
  endfunction : res
  task automatic irq_chk(input logic [2:0] e);
    @(negedge i_clk);
    chk_data({29'h0, o_zero_cross_irq, o_low_limit_irq, o_high_limit_irq}, {29'h0, e});
  endtask : irq_chk
  task automatic t_reset();
    rd_chk(ST, 32'h0, 2'h0);
    rd_chk(LS, 32'h0, 2'h0);
    rd_chk(RB, 32'h0, 2'h0);
    rd_chk(8'h10, 32'h0, ars_pkg::RESP_SLVERR);
    wr(8'h10, 16'hFFFF, ars_pkg::RESP_SLVERR);
    $display("test reset done");
  endtask : t_reset
  task automatic t_results();
    i_offset[47:16] <= {2{16'h0100}};
    conv(3'h1, 12'h050);
    conv(3'h2, 12'h010);
    rd_chk(ST, 32'h6, 2'h0);
    rd_chk(RB + 8'h04, res(12'h050, 16'h0100), 2'h0);
    rd_chk(RB + 8'h08, 32'hFF80, 2'h0);
    rd_chk(ST, 32'h0, 2'h0);
    wr(RB + 8'h04, 16'hFFFF, 2'h0);
    rd_chk(RB + 8'h04, 32'h7EF8, 2'h0);
    @(posedge i_clk);
    i_conv_a_valid <= 1'h1;
    i_conv_a_slot <= 3'h0;
    i_conv_a_raw <= 12'h123;
    i_conv_b_valid <= 1'h1;
    i_conv_b_slot <= 3'h4;
    i_conv_b_raw <= 12'h456;
    @(posedge i_clk);
    i_conv_a_valid <= 1'h0;
    i_conv_b_valid <= 1'h0;
    rd_chk(RB, res(12'h123, 16'h0), 2'h0);
    rd_chk(RB + 8'h10, res(12'h456, 16'h0), 2'h0);
    $display("test results done");
  endtask : t_results
  task automatic t_limits();
    i_high_limit[63:48] <= 16'h0400;
    i_offset[63:48] <= 16'h2000;
    i_low_limit[95:80] <= 16'h0400;
    conv(3'h3, 12'h080);
    conv(3'h5, 12'h080);
    rd_chk(LS, 32'h0, 2'h0);
    conv(3'h3, 12'h081);
    conv(3'h5, 12'h07F);
    conv(3'h3, 12'h000);
    conv(3'h0, 12'hFFF);
    rd_chk(LS, 32'h0820, 2'h0);
    rd_chk(ST, 32'h0329, 2'h0);
    irq_chk(3'h0);
    wr(CT, 16'h0001, 2'h0);
    irq_chk(3'h1);
    wr(LS, 16'h0000, 2'h0);
    rd_chk(LS, 32'h0820, 2'h0);
    wr(LS, 16'h0800, 2'h0);
    rd_chk(ST, 32'h0229, 2'h0);
    irq_chk(3'h0);
    wr(CT, 16'h0003, 2'h0);
    irq_chk(3'h2);
    wr(LS, 16'h0020, 2'h0);
    rd_chk(ST, 32'h0029, 2'h0);
    irq_chk(3'h0);
    $display("test limits done");
  endtask : t_limits
  task automatic t_zero();
    i_zero_cross_select[13:12] <= ars_pkg::ZC_ANY;
    i_offset[127:96] <= {2{16'h4000}};
    conv(3'h6, 12'h900);
    conv(3'h7, 12'h900);
    rd_chk(ZS, 32'h0, 2'h0);
    conv(3'h6, 12'h100);
    conv(3'h7, 12'h100);
    rd_chk(ZS, 32'h40, 2'h0);
    wr(CT, 16'h0004, 2'h0);
    irq_chk(3'h4);
    wr(ZS, 16'h0040, 2'h0);
    irq_chk(3'h0);
    // both slots stand negative now; one-way selections
    @(posedge i_clk);
    i_zero_cross_select[15:12] <= {ars_pkg::ZC_NEG_POS, ars_pkg::ZC_POS_NEG};
    conv(3'h6, 12'h900);
    conv(3'h7, 12'h900);
    rd_chk(ZS, 32'h80, 2'h0);
    conv(3'h6, 12'h100);
    rd_chk(ZS, 32'hC0, 2'h0);
    $display("test zero cross done");
  endtask : t_zero
  // main sequence
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'h1;
    t_reset();
    t_results();
    t_limits();
    t_zero();
    final_report();
  end
endmodule : ars_top_bench
bind ars_top ars_top_asserts u_chk (.*);
